// file: hw/daso_top.sv
// Digital audio serial output port, slave to an external audio master
// Functional notes
// - Master supplies bit clock and sync; we drive data
// - I2S: MSB at second capture edge after change
// - I2S: left while sync low, right while high
// - Left-justified: MSB at first capture edge
// - Left-justified: left while sync high, right low
// - DSP: right word follows left with no gap
// - DSP: option puts MSB on first or second edge
// - After MSB send bits downward to LSB
// - Idle bits after LSB until next sync event
// - Option selects falling edge as capture edge
// - Word length 8, 16, 20 or 24 bits
// - Frame rate follows external sync, 32 to 48 kHz
// - Output mode analog, digital or both; pin shared
// - Reset restores every setting to its default
// - De-emphasis 50 or 75 microseconds
// - Digital volume scaling and muting
// - De-emphasis code 1 is 50, code 2 is 75
`include "daso_defs.svh"
module daso_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic audio_bit_clock,
   input wire logic audio_frame_sync,
   output logic audio_serial_data,
   output logic third_general_output,
   output logic third_general_output_oe_b,
   input wire daso_pkg::daso_fmt_t fmt_sel,
   input wire daso_pkg::daso_len_t word_len_sel,
   input wire logic falling_capture,
   input wire logic dsp_late_msb,
   input wire daso_pkg::daso_mode_t out_mode_sel,
   input wire logic [1:0] deemph_time_constant_setting,
   input wire logic [`DASO_VW-1:0] volume_setting,
   input wire logic mute,
   input wire logic gpo_level,
   input wire logic [`DASO_SW-1:0] sample_left,
   input wire logic [`DASO_SW-1:0] sample_right,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic [`DASO_SW-1:0] analog_left,
   output logic [`DASO_SW-1:0] analog_right
);
   // ==========================================================
   // Settings
   daso_pkg::daso_fmt_t fmt_q;
   daso_pkg::daso_len_t len_q;
   daso_pkg::daso_mode_t mode_q;
   logic falling_q;
   logic late_q;
   logic [1:0] deemph_q;
   logic [`DASO_VW-1:0] vol_q;
   logic mute_q;
   logic gpo_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fmt_q <= daso_pkg::DASO_FMT_I2S;
         len_q <= daso_pkg::DASO_LEN_16;
         mode_q <= daso_pkg::DASO_MODE_ANALOG;
         falling_q <= 1'b0;
         late_q <= 1'b0;
         deemph_q <= `DASO_DEF_DEEMPH;
         vol_q <= `DASO_DEF_VOL;
         mute_q <= 1'b0;
         gpo_q <= 1'b0;
      end else begin
         fmt_q <= fmt_sel;
         len_q <= word_len_sel;
         mode_q <= out_mode_sel;
         falling_q <= falling_capture;
         late_q <= dsp_late_msb;
         deemph_q <= deemph_time_constant_setting;
         vol_q <= volume_setting;
         mute_q <= mute;
         gpo_q <= gpo_level;
      end
   end

   logic digital;
   logic analog_on;
   logic [4:0] len_m1;
   assign digital = (mode_q != daso_pkg::DASO_MODE_ANALOG);
   assign analog_on = (mode_q != daso_pkg::DASO_MODE_DIGITAL);

   always_comb begin
      case (len_q)
         daso_pkg::DASO_LEN_8: len_m1 = `DASO_LEN8_M1;
         daso_pkg::DASO_LEN_16: len_m1 = `DASO_LEN16_M1;
         daso_pkg::DASO_LEN_20: len_m1 = `DASO_LEN20_M1;
         daso_pkg::DASO_LEN_24: len_m1 = `DASO_LEN24_M1;
         default: len_m1 = `DASO_LEN16_M1;
      endcase
   end

   // ==========================================================
   // Sample path: processing, then FIFO
   logic [`DASO_FW-1:0] pr_data;
   logic pr_valid;
   logic pr_ready;
   logic [`DASO_FW-1:0] ff_data;
   logic ff_valid;
   logic ff_in_ready;
   logic ff_pop;

   // Analog-only mode never backs up on the FIFO
   assign pr_ready = digital ? ff_in_ready : 1'b1;

   daso_proc u_proc (
      .clk(clk),
      .rst_b(rst_b),
      .in_data({sample_right, sample_left}),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .out_data(pr_data),
      .out_valid(pr_valid),
      .out_ready(pr_ready),
      .deemph(deemph_q),
      .volume(vol_q),
      .mute(mute_q)
   );

   daso_fifo #(.W(`DASO_FW), .D(`DASO_FD)) u_fifo (
      .clk(clk),
      .rst_b(rst_b),
      .in_data(pr_data),
      .in_valid(pr_valid && digital),
      .in_ready(ff_in_ready),
      .out_data(ff_data),
      .out_valid(ff_valid),
      .out_ready(ff_pop)
   );

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         analog_left <= '0;
         analog_right <= '0;
      end else if (pr_valid && pr_ready && analog_on) begin
         analog_left <= pr_data[`DASO_SW-1:0];
         analog_right <= pr_data[`DASO_FW-1:`DASO_SW];
      end
   end

   // ==========================================================
   // Shared pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         third_general_output <= 1'b0;
         third_general_output_oe_b <= 1'b0;
      end else begin
         third_general_output <= digital ? 1'b0 : gpo_q;
         third_general_output_oe_b <= digital;
      end
   end

   // ==========================================================
   // Pin synchronisers and edge finding
   logic bclk_s1_q;
   logic bclk_s2_q;
   logic bclk_s3_q;
   logic fs_s1_q;
   logic fs_s2_q;
   logic fs_s3_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bclk_s1_q <= 1'b0;
         bclk_s2_q <= 1'b0;
         bclk_s3_q <= 1'b0;
         fs_s1_q <= 1'b0;
         fs_s2_q <= 1'b0;
         fs_s3_q <= 1'b0;
      end else begin
         bclk_s1_q <= audio_bit_clock;
         bclk_s2_q <= bclk_s1_q;
         bclk_s3_q <= bclk_s2_q;
         fs_s1_q <= audio_frame_sync;
         fs_s2_q <= fs_s1_q;
         fs_s3_q <= fs_s2_q;
      end
   end

   logic rise;
   logic fall;
   logic cap_e;
   logic lau_e;
   assign rise = bclk_s2_q && !bclk_s3_q;
   assign fall = !bclk_s2_q && bclk_s3_q;
   // Data launches on the edge opposite to capture
   assign cap_e = digital && (falling_q ? fall : rise);
   assign lau_e = digital && (falling_q ? rise : fall);

   // ==========================================================
   // Frame events
   logic is_dsp;
   logic ev_lvl;
   logic ev_dsp;
   logic ev;
   logic left_ev;
   logic [1:0] delay;
   assign is_dsp = (fmt_q == daso_pkg::DASO_FMT_DSP);
   // Level change is seen at once so a zero-delay MSB meets setup
   assign ev_lvl = digital && !is_dsp && (fs_s2_q != fs_s3_q);
   assign ev_dsp = cap_e && is_dsp && fs_s2_q;
   assign ev = ev_lvl || ev_dsp;
   assign left_ev = is_dsp ||
      ((fmt_q == daso_pkg::DASO_FMT_I2S) ? !fs_s2_q : fs_s2_q);

   always_comb begin
      case (fmt_q)
         daso_pkg::DASO_FMT_I2S: delay = `DASO_WAIT_ONE;
         daso_pkg::DASO_FMT_LJ: delay = `DASO_WAIT_NONE;
         daso_pkg::DASO_FMT_DSP:
            delay = late_q ? `DASO_WAIT_TWO : `DASO_WAIT_ONE;
         default: delay = `DASO_WAIT_ONE;
      endcase
   end

   // Underrun sends silence rather than stale audio
   logic [`DASO_SW-1:0] left_word;
   logic [`DASO_SW-1:0] ev_word;
   assign ff_pop = ev && left_ev;
   assign left_word = ff_valid ? ff_data[`DASO_SW-1:0] : '0;

   // ==========================================================
   // Serialiser
   daso_pkg::daso_state_t state_q;
   logic [`DASO_SW-1:0] sh_q;
   logic [`DASO_SW-1:0] pend_q;
   logic [`DASO_SW-1:0] right_q;
   logic [4:0] cnt_q;
   logic [1:0] wait_q;
   logic chan_right_q;
   logic load_now;
   logic [`DASO_SW-1:0] load_word;
   logic dsp_follow;
   assign ev_word = left_ev ? left_word : right_q;
   assign dsp_follow = (state_q == daso_pkg::DASO_SHIFT) && lau_e &&
      (cnt_q == '0) && is_dsp && !chan_right_q && !ev;

   always_comb begin
      load_now = 1'b0;
      load_word = right_q;
      if (ev) begin
         load_now = (delay == `DASO_WAIT_NONE);
         load_word = ev_word;
      end else if (state_q == daso_pkg::DASO_WAIT && lau_e &&
            wait_q == `DASO_WAIT_ONE) begin
         load_now = 1'b1;
         load_word = pend_q;
      end else if (dsp_follow) begin
         load_now = 1'b1;
         load_word = right_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         right_q <= '0;
         chan_right_q <= 1'b0;
      end else if (ff_pop) begin
         right_q <= ff_valid ? ff_data[`DASO_FW-1:`DASO_SW] : '0;
         chan_right_q <= 1'b0;
      end else if (ev || dsp_follow) begin
         chan_right_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= daso_pkg::DASO_IDLE;
         wait_q <= `DASO_WAIT_NONE;
         pend_q <= '0;
      end else if (!digital) begin
         state_q <= daso_pkg::DASO_IDLE;
      end else if (load_now) begin
         state_q <= daso_pkg::DASO_SHIFT;
      end else if (ev) begin
         state_q <= daso_pkg::DASO_WAIT;
         wait_q <= delay;
         pend_q <= ev_word;
      end else if (lau_e) begin
         case (state_q)
            daso_pkg::DASO_WAIT: wait_q <= wait_q - 1'b1;
            daso_pkg::DASO_SHIFT: begin
               if (cnt_q == '0) begin
                  state_q <= daso_pkg::DASO_IDLE;
               end
            end
            default: state_q <= daso_pkg::DASO_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_q <= '0;
         cnt_q <= '0;
      end else if (load_now) begin
         sh_q <= {load_word[`DASO_SW-2:0], 1'b0};
         cnt_q <= len_m1;
      end else if (lau_e && state_q == daso_pkg::DASO_SHIFT &&
            cnt_q != '0 && !ev) begin
         sh_q <= {sh_q[`DASO_SW-2:0], 1'b0};
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // A packed frame's last bit still leaves on the event's edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         audio_serial_data <= 1'b0;
      end else if (!digital) begin
         audio_serial_data <= 1'b0;
      end else if (load_now) begin
         audio_serial_data <= load_word[`DASO_SW-1];
      end else if (lau_e) begin
         audio_serial_data <= (state_q == daso_pkg::DASO_SHIFT &&
            cnt_q != '0) ? sh_q[`DASO_SW-1] : 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   pin_release_a: assert property (
      digital |=> third_general_output_oe_b)
      else $error("shared pin driven in digital mode");
   pin_drive_a: assert property (
      !digital |=> !third_general_output_oe_b &&
      third_general_output == $past(gpo_q))
      else $error("shared pin not driven in analog mode");
   lj_msb_a: assert property (
      ev_lvl && fmt_q == daso_pkg::DASO_FMT_LJ && fs_s2_q && ff_valid
      |=> state_q == daso_pkg::DASO_SHIFT &&
      audio_serial_data == $past(ff_data[`DASO_SW-1]))
      else $error("left-justified MSB not launched");
   i2s_left_a: assert property (
      ev_lvl && fmt_q == daso_pkg::DASO_FMT_I2S && !fs_s2_q
      |=> !chan_right_q && state_q == daso_pkg::DASO_WAIT)
      else $error("I2S left word not started on low sync");
   len_load_a: assert property (
      load_now && digital |=> cnt_q == $past(len_m1))
      else $error("bit count does not match word length");
   bit_order_a: assert property (
      state_q == daso_pkg::DASO_SHIFT && lau_e && cnt_q != '0 && !ev
      |=> audio_serial_data == $past(sh_q[`DASO_SW-1]) &&
      cnt_q == $past(cnt_q) - 5'h01)
      else $error("bits not sent in descending order");
   idle_tail_a: assert property (
      state_q == daso_pkg::DASO_SHIFT && lau_e && cnt_q == '0 &&
      !load_now && !ev |=> state_q == daso_pkg::DASO_IDLE &&
      !audio_serial_data)
      else $error("line not idle after LSB");
   dsp_right_a: assert property (
      dsp_follow |=> chan_right_q && state_q == daso_pkg::DASO_SHIFT &&
      audio_serial_data == $past(right_q[`DASO_SW-1]))
      else $error("DSP right word not contiguous");
   dsp_late_a: assert property (
      ev_dsp && late_q |=> state_q == daso_pkg::DASO_WAIT &&
      wait_q == `DASO_WAIT_TWO)
      else $error("DSP late MSB delay wrong");
   dsp_sync_a: assert property (
      ev_dsp |-> (falling_q ? fall : rise) && fs_s2_q)
      else $error("DSP event off capture edge");

   i2s_frame_c: cover property (
      ev_lvl && fmt_q == daso_pkg::DASO_FMT_I2S ##[1:400]
      state_q == daso_pkg::DASO_SHIFT);
   dsp_pair_c: cover property (dsp_follow);
   fall_cap_c: cover property (falling_q && load_now);
endmodule // daso_top

// file: hw/daso_defs.svh
// Constants of the digital audio serial output block
`ifndef DASO_DEFS_SVH
`define DASO_DEFS_SVH
`define DASO_SW 24
`define DASO_FW 48
`define DASO_FD 8
`define DASO_VW 6
`define DASO_DE_50US 2'h1
`define DASO_DE_75US 2'h2
`define DASO_DE_SH50 5'h01
`define DASO_DE_SH75 5'h02
`define DASO_DEF_DEEMPH 2'h2
`define DASO_DEF_VOL 6'h3f
`define DASO_VOL_SH 6
`define DASO_LEN8_M1 5'h07
`define DASO_LEN16_M1 5'h0f
`define DASO_LEN20_M1 5'h13
`define DASO_LEN24_M1 5'h17
`define DASO_WAIT_NONE 2'h0
`define DASO_WAIT_ONE 2'h1
`define DASO_WAIT_TWO 2'h2
`endif

// file: hw/daso_pkg.sv
// Types of the digital audio serial output block
package daso_pkg;
   typedef enum logic [1:0] {DASO_FMT_I2S, DASO_FMT_LJ, DASO_FMT_DSP}
      daso_fmt_t;
   typedef enum logic [1:0] {DASO_MODE_ANALOG, DASO_MODE_DIGITAL,
      DASO_MODE_BOTH} daso_mode_t;
   typedef enum logic [1:0] {DASO_LEN_8, DASO_LEN_16, DASO_LEN_20,
      DASO_LEN_24} daso_len_t;
   typedef enum logic [1:0] {DASO_IDLE, DASO_WAIT, DASO_SHIFT}
      daso_state_t;
endpackage

// file: hw/daso_fifo.sv
// Sample FIFO between audio processing and the serialiser
module daso_fifo #(
   parameter int W = 48,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // daso_fifo

// file: hw/daso_proc.sv
// De-emphasis, volume and mute on the stereo sample pair
`include "daso_defs.svh"
module daso_proc (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [`DASO_FW-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [`DASO_FW-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   input wire logic [1:0] deemph,
   input wire logic [`DASO_VW-1:0] volume,
   input wire logic mute
);
   logic fire;
   logic [`DASO_FW-1:0] res;
   logic out_valid_d;
   logic [4:0] shamt;

   // Ready is a flop: one sample in flight keeps it exact
   assign fire = in_valid && in_ready;
   assign out_valid_d = out_valid ? !out_ready : fire;
   assign shamt = (deemph == `DASO_DE_50US) ? `DASO_DE_SH50 : `DASO_DE_SH75;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         logic signed [`DASO_SW-1:0] x;
         logic signed [`DASO_SW-1:0] y_q;
         logic signed [`DASO_SW:0] diff;
         logic signed [`DASO_SW:0] y_n;
         logic signed [`DASO_SW+6:0] prod;
         assign x = in_data[ch*`DASO_SW +: `DASO_SW];
         assign diff = x - y_q;
         // Unknown codes bypass the filter
         assign y_n = (deemph == `DASO_DE_50US || deemph == `DASO_DE_75US) ?
            y_q + (diff >>> shamt) : {x[`DASO_SW-1], x};
         // A part-select is unsigned; keep the sign for negative samples
         assign prod = $signed(y_n[`DASO_SW-1:0]) *
            $signed({1'b0, volume});
         assign res[ch*`DASO_SW +: `DASO_SW] = mute ? '0 :
            prod[`DASO_SW+`DASO_VOL_SH-1:`DASO_VOL_SH];
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               y_q <= '0;
            end else if (fire) begin
               y_q <= y_n[`DASO_SW-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid <= 1'b0;
         in_ready <= 1'b1;
      end else begin
         out_valid <= out_valid_d;
         in_ready <= !out_valid_d;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_data <= '0;
      end else if (fire) begin
         out_data <= res;
      end
   end

   mute_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
      fire && mute |=> out_data == '0)
      else $error("muted sample not zero");
endmodule // daso_proc

// file: tb/daso_master.sv
// Audio bus master model: bit clock, frame sync and data capture
module daso_master (
   output logic bclk,
   output logic fs,
   input wire logic sdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [23:0] left_word;
   logic [23:0] right_word;
   logic extra;
   initial begin
      bclk = 1'b0;
      fs = 1'b0;
   end
   // =====================================================
   // Bit period: capture edge, then launch edge with sync
   task automatic cycle(input logic cap, input logic nxt, output logic b);
      bclk = cap;
      b = sdata;
      #80;
      bclk = ~cap;
      fs = nxt;
      #80;
   endtask
   // =====================================================
   // One frame; clock stands still before and after it
   task automatic frame(input int fmt, input int len, input logic fall,
      input int late);
      int idx;
      int ch;
      int n;
      logic b;
      logic lft;
      left_word = 24'h000000;
      right_word = 24'h000000;
      extra = 1'b0;
      bclk = fall;
      lft = (fmt == 1);
      n = (fmt == 2) ? 2 * len + 4 : 64;
      fs = (fmt == 2) ? 1'b0 : ~lft;
      #160;
      fs = (fmt == 2) ? 1'b1 : lft;
      #80;
      for (int k = 0; k < n; k++) begin
         if (fmt == 2) begin
            cycle(~fall, 1'b0, b);
            // Late option puts one lead-in bit before the MSB
            idx = k - 1 - late;
            ch = (idx >= len) ? 1 : 0;
            idx = idx - ch * len;
         end else begin
            // Sync flips only at the slot boundary
            cycle(~fall, (k == 31) ? ~fs : fs, b);
            ch = k / 32;
            // I2S MSB comes one capture edge after left-justified
            idx = k % 32 - ((fmt == 0) ? 1 : 0);
         end
         if (idx >= 0 && idx < len && ch == 0) begin
            left_word = {left_word[22:0], b};
         end else if (idx >= 0 && idx < len) begin
            right_word = {right_word[22:0], b};
         end else if (idx >= len) begin
            extra = extra | b;
         end
      end
   endtask
endmodule // daso_master

// file: tb/digital_audio_serial_out_tb.sv
// Self-checking bench of the digital audio serial output port
module digital_audio_serial_out_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_b, sdata, tgo, tgo_oe_b, falling_capture, dsp_late_msb;
   logic mute, gpo_level, sample_valid, sample_ready;
   logic [1:0] deemph;
   logic [5:0] vol;
   logic [23:0] s_l, s_r, an_l, an_r;
   wire logic bclk, fs;
   daso_pkg::daso_fmt_t fmt;
   daso_pkg::daso_len_t wlen;
   daso_pkg::daso_mode_t mode;
   int n_errors, num_checks;
   int lens[4] = '{8, 16, 20, 24};

   always #5 clk = ~clk;

   daso_top DUT (.clk(clk), .rst_b(rst_b), .audio_bit_clock(bclk),
      .audio_frame_sync(fs), .audio_serial_data(sdata),
      .third_general_output(tgo), .third_general_output_oe_b(tgo_oe_b),
      .fmt_sel(fmt), .word_len_sel(wlen), .falling_capture(falling_capture),
      .dsp_late_msb(dsp_late_msb), .out_mode_sel(mode),
      .deemph_time_constant_setting(deemph), .volume_setting(vol),
      .mute(mute), .gpo_level(gpo_level), .sample_left(s_l),
      .sample_right(s_r), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .analog_left(an_l), .analog_right(an_r));

   daso_master M (.bclk(bclk), .fs(fs), .sdata(sdata));

   // =====================================================
   // Compare, report and bus tasks
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic reset_dut;
      @(negedge clk);
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      chk_bit(tgo_oe_b, 1'b0);
      chk_bit(sample_ready, 1'b1);
      chk_bit(sdata, 1'b0);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   // Offer one pair; gives up after a bounded wait
   task automatic push(input logic [23:0] l, input logic [23:0] r,
      output logic ok);
      s_l = l;
      s_r = r;
      sample_valid = 1'b1;
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         if (sample_ready === 1'b1) ok = 1'b1;
         @(negedge clk);
      end
      sample_valid = 1'b0;
      @(negedge clk);
   endtask
   // Volume 32 of 64 halves the sample
   function automatic logic [23:0] half(input logic [23:0] x);
      return {x[23], x[23:1]};
   endfunction
   task automatic set_link(input int f, input int l);
      fmt = daso_pkg::daso_fmt_t'((f == 3) ? 2 : f);
      wlen = daso_pkg::daso_len_t'(l);
      falling_capture = l[0];
      dsp_late_msb = (f == 3);
      repeat (2) @(negedge clk);
   endtask
   task automatic link_frame(input int f, input int l,
      input logic [23:0] el, input logic [23:0] er);
      int sh;
      sh = 24 - lens[l];
      M.frame((f == 3) ? 2 : f, lens[l], falling_capture, (f == 3) ? 1 : 0);
      if (f >= 2) begin
         chk(M.left_word, el >> sh);
         chk(M.right_word, er >> sh);
         chk_bit(M.extra, 1'b0);
      end else begin
         chk(M.left_word, el >> sh);
         chk(M.right_word, er >> sh);
         chk_bit(M.extra, 1'b0);
      end
      @(negedge clk);
   endtask

   // =====================================================
   // Scenarios
   task automatic t_gpo;
      logic ok;
      gpo_level = 1'b1;
      repeat (3) @(negedge clk);
      chk_bit(tgo, 1'b1);
      chk_bit(tgo_oe_b, 1'b0);
      push(24'h123456, 24'h876543, ok);
      repeat (3) @(negedge clk);
      chk(an_l, half(24'h123456));
      chk(an_r, half(24'h876543));
      set_link(1, 1);
      link_frame(1, 1, 24'h000000, 24'h000000);
      mode = daso_pkg::DASO_MODE_DIGITAL;
      repeat (3) @(negedge clk);
      chk_bit(tgo_oe_b, 1'b1);
      chk_bit(tgo, 1'b0);
   endtask
   task automatic t_proc;
      logic ok;
      logic [23:0] e[2][2] = '{'{24'h040000, 24'h060000},
         '{24'h020000, 24'h038000}};
      mode = daso_pkg::DASO_MODE_ANALOG;
      for (int d = 0; d < 2; d++) begin
         // Setting must be registered before the first sample fires
         deemph = 2'(d + 1);
         reset_dut;
         for (int i = 0; i < 2; i++) begin
            push(24'h100000, 24'h100000, ok);
            repeat (3) @(negedge clk);
            chk(an_l, e[d][i]);
            chk(an_r, e[d][i]);
         end
      end
      deemph = 2'h0;
      mute = 1'b1;
      @(negedge clk);
      push(24'h100000, 24'h100000, ok);
      repeat (3) @(negedge clk);
      chk(an_l, 24'h000000);
      mute = 1'b0;
   endtask
   task automatic t_formats;
      logic ok;
      logic [23:0] l_v, r_v;
      mode = daso_pkg::DASO_MODE_DIGITAL;
      for (int f = 0; f < 4; f++) begin
         for (int l = 0; l < 4; l++) begin
            l_v = 24'hc35a96 + 24'(4 * f + l);
            r_v = 24'h3ca569 - 24'(f + l);
            set_link(f, l);
            push(l_v, r_v, ok);
            link_frame(f, l, half(l_v), half(r_v));
         end
      end
      chk(an_r, 24'h000000);
   endtask
   task automatic t_fifo;
      logic ok;
      int cnt;
      cnt = 0;
      mode = daso_pkg::DASO_MODE_BOTH;
      set_link(1, 1);
      chk_bit(tgo_oe_b, 1'b1);
      for (int i = 0; i < 12; i++) begin
         push(24'h010101 * 24'(i + 1), 24'h202020 + 24'(i), ok);
         if (ok) cnt++;
      end
      chk(24'(cnt), 24'h000009);
      for (int i = 0; i < 10; i++) begin
         link_frame(1, 1, (i < 9) ? half(24'h010101 * 24'(i + 1)) : 24'h0,
            (i < 9) ? half(24'h202020 + 24'(i)) : 24'h0);
      end
      // Both mode: the last pair also reached the analog registers
      chk(an_l, half(24'h090909));
      chk(an_r, half(24'h202028));
   endtask

   initial begin
      n_errors = 0;
      num_checks = 0;
      rst_b = 1'b0;
      fmt = daso_pkg::DASO_FMT_I2S;
      wlen = daso_pkg::DASO_LEN_16;
      mode = daso_pkg::DASO_MODE_ANALOG;
      falling_capture = 1'b0;
      dsp_late_msb = 1'b0;
      deemph = 2'h0;
      vol = 6'h20;
      mute = 1'b0;
      gpo_level = 1'b0;
      s_l = 24'h000000;
      s_r = 24'h000000;
      sample_valid = 1'b0;
      reset_dut;
      t_gpo;
      t_proc;
      t_formats;
      t_fifo;
      wrap_up;
   end
   // Frames dominate: about 27 frames of at most some 1,050 cycles each
   initial begin
      #500_000;
      n_errors++;
      wrap_up;
   end
endmodule // digital_audio_serial_out_tb
